// ==== design/cfr_defines.svh ====
// Constants for the clamp flag, temperature selection and reference configuration block
`ifndef CFR_DEFINES_SVH
`define CFR_DEFINES_SVH
`define CFR_NUM_INPUTS        16
`define CFR_TEMP_CHAN_CODE    5'h0F
`define CFR_CHAN_CODE_BITS    5
`define CFR_REF_RANGE_OPTIONS 3'h5
`define CFR_REF_RANGE_RST     3'h0
`define CFR_REF_LOWCUR_RST    1'h1
`define CFR_OSR_ONE           2'h0
`define CFR_CODING_UNIPOLAR   1'h0
`define CFR_POR_CYCLES        8'h10
`endif

// ==== design/cfr_pkg.sv ====
// Types shared by the clamp flag and configuration block
package cfr_pkg;
   typedef enum logic [1:0] {
      CFR_SEQ_OFF,
      CFR_SEQ_STANDARD,
      CFR_SEQ_ADVANCED,
      CFR_SEQ_COMMAND
   } cfr_seq_mode_t;
   typedef enum {
      CFR_POR_IDLE,
      CFR_POR_LOAD,
      CFR_POR_DONE
   } cfr_por_state_t;
endpackage

// ==== design/cfr_sync.sv ====
// Two-stage level synchroniser, parameterised width
`timescale 1ns/1ns
module cfr_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             mclk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_sync_out;

   always_comb begin
      next_stage1   = async_in;
      next_sync_out = stage1;
      if (srst) begin
         next_stage1   = '0;
         next_sync_out = '0;
      end
   end

   always_ff @(posedge mclk) begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
   end
endmodule

// ==== design/cfr_top.sv ====
// Clamp flags, temperature sensor selection and reference configuration
`timescale 1ns/1ns
`include "cfr_defines.svh"
// Operation
// - Live clamp bit per each of 16 inputs
// - Sticky summary flag, cleared by read when idle
// - Live common input clamp bit
// - Clamp bits readable in register configuration mode
// - Alert status equals OR of input clamps
// - Optionally OR threshold alert into alert status
// - Sequencer appends temperature conversion after last channel
// - Channel code 0x0F selects temperature sensor
// - No threshold alerts for temperature results
// - Temperature results unipolar, no oversampling
// - Five-option reference range field
// - Reference low-current enable, set after reset
// - Core power-up loads all defaults
// - Power-on reset once both supplies present
module cfr_top
   import cfr_pkg::*;
#(
   parameter int NUM_INPUTS = `CFR_NUM_INPUTS
) (
   input  wire logic                  mclk,
   input  wire logic                  srst,
   input  wire logic                  io_supply_good,
   input  wire logic                  core_supply_good,
   input  wire logic [NUM_INPUTS-1:0] input_clamp_raw,
   input  wire logic                  common_clamp_raw,
   input  wire logic                  reg_config_mode,
   input  wire logic                  status_read,
   input  wire logic                  alert_or_threshold_sel,
   input  wire logic                  threshold_alert,
   input  wire logic                  temp_enable_wr,
   input  wire logic                  temp_enable_in,
   input  wire cfr_seq_mode_t         seq_mode,
   input  wire logic                  seq_last_channel_done,
   input  wire logic                  cmd_code_valid,
   input  wire logic [4:0]            cmd_channel_code,
   input  wire logic                  cfg_low_kickback,
   input  wire logic [1:0]            cfg_oversampling_ratio,
   input  wire logic                  cfg_coding,
   input  wire logic                  thresh_hit_raw,
   input  wire logic                  ref_range_wr,
   input  wire logic [2:0]            ref_range_in,
   input  wire logic                  ref_lowcur_wr,
   input  wire logic                  ref_lowcur_in,
   output logic      [NUM_INPUTS-1:0] input_clamp_active_bit,
   output logic                       common_input_clamp_bit,
   output logic                       clamp_summary_flag,
   output logic      [NUM_INPUTS-1:0] clamp_state_view,
   output logic                       clamp_view_valid,
   output logic                       overvoltage_alert_status_bit,
   output logic                       temp_enable,
   output logic                       temp_convert,
   output logic                       eff_low_kickback,
   output logic      [1:0]            eff_oversampling_ratio,
   output logic                       eff_coding,
   output logic                       threshold_alert_out,
   output logic      [2:0]            ref_range,
   output logic                       reference_low_current_enable,
   output logic                       por_active,
   output logic                       core_ready
);
   // Vector ports and the OR tree are sized for at most one word of inputs
   if (NUM_INPUTS < 1 || NUM_INPUTS > 32) begin : g_bad_inputs
      $error("NUM_INPUTS out of range");
   end

   function automatic logic is_temp_code(input logic [4:0] code);
      return code == `CFR_TEMP_CHAN_CODE;
   endfunction

   // Raw comparators and supply detectors are asynchronous
   logic [NUM_INPUTS-1:0] clamp_sync;
   logic                  common_sync;
   logic                  io_good_sync;
   logic                  core_good_sync;

   cfr_sync #(.WIDTH(NUM_INPUTS)) u_sync_clamp (
      .mclk     (mclk),
      .srst     (srst),
      .async_in (input_clamp_raw),
      .sync_out (clamp_sync)
   );
   cfr_sync #(.WIDTH(3)) u_sync_misc (
      .mclk     (mclk),
      .srst     (srst),
      .async_in ({common_clamp_raw, io_supply_good, core_supply_good}),
      .sync_out ({common_sync, io_good_sync, core_good_sync})
   );

   // Power-on reset sequencing
   cfr_por_state_t por_state;
   cfr_por_state_t next_por_state;
   logic [7:0]     por_count;
   logic [7:0]     next_por_count;
   logic           next_por_active;
   logic           next_core_ready;
   logic           both_good;
   logic           load_defaults;

   assign both_good     = io_good_sync && core_good_sync;
   assign load_defaults = srst || (por_state != CFR_POR_DONE);

   always_comb begin
      next_por_state  = por_state;
      next_por_count  = por_count;
      case (por_state)
         CFR_POR_IDLE: begin
            next_por_count = '0;
            if (both_good)
               next_por_state = CFR_POR_LOAD;
         end
         CFR_POR_LOAD: begin
            next_por_count = por_count + 8'h01;
            if (!both_good)
               next_por_state = CFR_POR_IDLE;
            else if (por_count == `CFR_POR_CYCLES - 8'h01)
               next_por_state = CFR_POR_DONE;
         end
         CFR_POR_DONE: begin
            // Losing either supply erases the configuration
            if (!both_good)
               next_por_state = CFR_POR_IDLE;
         end
         default: next_por_state = CFR_POR_IDLE;
      endcase
      if (srst) begin
         next_por_state = CFR_POR_IDLE;
         next_por_count = '0;
      end
      next_por_active = (next_por_state != CFR_POR_DONE);
      next_core_ready = (next_por_state == CFR_POR_DONE);
   end

   always_ff @(posedge mclk) begin
      por_state  <= next_por_state;
      por_count  <= next_por_count;
      por_active <= next_por_active;
      core_ready <= next_core_ready;
   end

   // Clamp status
   logic [NUM_INPUTS-1:0] next_input_clamp;
   logic                  next_common;
   logic                  next_summary;
   logic [NUM_INPUTS-1:0] next_view;
   logic                  next_view_valid;
   logic                  next_alert;
   logic                  any_clamp;

   assign any_clamp = |clamp_sync;

   always_comb begin
      next_input_clamp = clamp_sync;
      next_common      = common_sync;
      // Set wins over a clearing read
      next_summary     = clamp_summary_flag;
      if (status_read && !any_clamp)
         next_summary = 1'b0;
      if (any_clamp)
         next_summary = 1'b1;
      next_view_valid  = reg_config_mode;
      next_view        = reg_config_mode ? clamp_sync : clamp_state_view;
      next_alert       = any_clamp || (alert_or_threshold_sel && threshold_alert);
      if (load_defaults) begin
         next_input_clamp = '0;
         next_common      = 1'b0;
         next_summary     = 1'b0;
         next_view        = '0;
         next_view_valid  = 1'b0;
         next_alert       = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      input_clamp_active_bit       <= next_input_clamp;
      common_input_clamp_bit       <= next_common;
      clamp_summary_flag           <= next_summary;
      clamp_state_view             <= next_view;
      clamp_view_valid             <= next_view_valid;
      overvoltage_alert_status_bit <= next_alert;
   end

   // Temperature sensor selection and forced conversion settings
   logic       next_temp_enable;
   logic       next_temp_convert;
   logic       next_eff_lk;
   logic [1:0] next_eff_osr;
   logic       next_eff_coding;
   logic       next_thr_out;
   logic       seq_on;
   logic       cmd_on;

   assign seq_on = (seq_mode == CFR_SEQ_STANDARD) || (seq_mode == CFR_SEQ_ADVANCED);
   assign cmd_on = (seq_mode == CFR_SEQ_COMMAND);

   always_comb begin
      next_temp_enable  = temp_enable_wr ? temp_enable_in : temp_enable;
      next_temp_convert = 1'b0;
      if (seq_on && temp_enable && seq_last_channel_done)
         next_temp_convert = 1'b1;
      if (cmd_on && cmd_code_valid && is_temp_code(cmd_channel_code))
         next_temp_convert = 1'b1;
      next_eff_lk     = next_temp_convert ? 1'b1 : cfg_low_kickback;
      next_eff_osr    = next_temp_convert ? `CFR_OSR_ONE : cfg_oversampling_ratio;
      next_eff_coding = next_temp_convert ? `CFR_CODING_UNIPOLAR : cfg_coding;
      next_thr_out    = thresh_hit_raw && !temp_convert;
      if (load_defaults) begin
         next_temp_enable  = 1'b0;
         next_temp_convert = 1'b0;
         next_eff_lk       = 1'b0;
         next_eff_osr      = `CFR_OSR_ONE;
         next_eff_coding   = `CFR_CODING_UNIPOLAR;
         next_thr_out      = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      temp_enable            <= next_temp_enable;
      temp_convert           <= next_temp_convert;
      eff_low_kickback       <= next_eff_lk;
      eff_oversampling_ratio <= next_eff_osr;
      eff_coding             <= next_eff_coding;
      threshold_alert_out    <= next_thr_out;
   end

   // Reference configuration; consistency with low-kickback is the host's duty
   logic [2:0] next_ref_range;
   logic       next_ref_lowcur;

   always_comb begin
      next_ref_range  = ref_range;
      next_ref_lowcur = reference_low_current_enable;
      // Out-of-range codes are ignored so the field always holds a legal option
      if (ref_range_wr && ref_range_in < `CFR_REF_RANGE_OPTIONS)
         next_ref_range = ref_range_in;
      if (ref_lowcur_wr)
         next_ref_lowcur = ref_lowcur_in;
      if (load_defaults) begin
         next_ref_range  = `CFR_REF_RANGE_RST;
         next_ref_lowcur = `CFR_REF_LOWCUR_RST;
      end
   end

   always_ff @(posedge mclk) begin
      ref_range                    <= next_ref_range;
      reference_low_current_enable <= next_ref_lowcur;
   end

   // Checks
   property p_summary_sets;
      @(posedge mclk) disable iff (load_defaults)
      any_clamp |=> clamp_summary_flag;
   endproperty
   a_summary_sets: assert property (p_summary_sets) else $error("summary flag not set");

   property p_summary_holds;
      @(posedge mclk) disable iff (load_defaults)
      clamp_summary_flag && !status_read |=> clamp_summary_flag;
   endproperty
   a_summary_holds: assert property (p_summary_holds) else $error("summary flag dropped without read");

   // First edge after defaults still shows the cleared value, so skip it
   property p_live_bits;
      @(posedge mclk) disable iff (load_defaults)
      !$past(load_defaults) |-> input_clamp_active_bit == $past(clamp_sync);
   endproperty
   a_live_bits: assert property (p_live_bits) else $error("live clamp bits stale");

   property p_common_bit;
      @(posedge mclk) disable iff (load_defaults)
      !$past(load_defaults) |-> common_input_clamp_bit == $past(common_sync);
   endproperty
   a_common_bit: assert property (p_common_bit) else $error("common clamp bit stale");

   property p_alert;
      @(posedge mclk) disable iff (load_defaults)
      !alert_or_threshold_sel |=> overvoltage_alert_status_bit == $past(any_clamp);
   endproperty
   a_alert: assert property (p_alert) else $error("alert not OR of clamps");

   property p_alert_thr;
      @(posedge mclk) disable iff (load_defaults)
      alert_or_threshold_sel && threshold_alert |=> overvoltage_alert_status_bit;
   endproperty
   a_alert_thr: assert property (p_alert_thr) else $error("threshold alert not merged");

   property p_temp_forced;
      @(posedge mclk) disable iff (srst)
      temp_convert |-> eff_low_kickback && eff_oversampling_ratio == `CFR_OSR_ONE;
   endproperty
   a_temp_forced: assert property (p_temp_forced) else $error("temp settings not forced");

   property p_temp_code;
      @(posedge mclk) disable iff (load_defaults)
      cmd_on && cmd_code_valid && is_temp_code(cmd_channel_code) |=> temp_convert;
   endproperty
   a_temp_code: assert property (p_temp_code) else $error("temp code not decoded");

   property p_no_temp_thr;
      @(posedge mclk) disable iff (load_defaults)
      temp_convert |=> !threshold_alert_out;
   endproperty
   a_no_temp_thr: assert property (p_no_temp_thr) else $error("threshold on temperature");

   property p_lowcur_default;
      @(posedge mclk)
      srst |=> reference_low_current_enable;
   endproperty
   a_lowcur_default: assert property (p_lowcur_default) else $error("low-current not default on");
endmodule

// ==== test/cfr_host_model.sv ====
// Host controller model: status reads and configuration writes
`timescale 1ns/1ns
module cfr_host_model (
   input  wire logic       mclk,
   input  wire logic       all_low_kickback,
   output logic            status_read,
   output logic            temp_enable_wr,
   output logic            temp_enable_in,
   output logic            ref_range_wr,
   output logic [2:0]      ref_range_in,
   output logic            ref_lowcur_wr,
   output logic            ref_lowcur_in
);
   initial begin
      status_read = 1'h0;
      temp_enable_wr = 1'h0;
      temp_enable_in = 1'h0;
      ref_range_wr = 1'h0;
      ref_range_in = 3'h0;
      ref_lowcur_wr = 1'h0;
      ref_lowcur_in = 1'h0;
   end
   task automatic read_status();
      @(negedge mclk);
      status_read = 1'h1;
      @(negedge mclk);
      status_read = 1'h0;
   endtask
   // Data lines toggle after the strobe so stale values never pass
   task automatic write_range(input logic [2:0] v);
      @(negedge mclk);
      ref_range_wr = 1'h1;
      ref_range_in = v;
      @(negedge mclk);
      ref_range_wr = 1'h0;
      ref_range_in = ~v;
   endtask
   task automatic write_lowcur(input logic v);
      @(negedge mclk);
      ref_lowcur_wr = 1'h1;
      ref_lowcur_in = v & all_low_kickback;
      @(negedge mclk);
      ref_lowcur_wr = 1'h0;
      ref_lowcur_in = ~ref_lowcur_in;
   endtask
   task automatic write_temp(input logic v);
      @(negedge mclk);
      temp_enable_wr = 1'h1;
      temp_enable_in = v;
      @(negedge mclk);
      temp_enable_wr = 1'h0;
      temp_enable_in = ~v;
   endtask
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the clamp flag and configuration block
`timescale 1ns/1ns
module tb;
   import cfr_pkg::*;
   logic mclk, srst, io_good, core_good, cfg_mode, sel, th_alert;
   logic done, cmd_v, lkb, coding, th_hit, com_raw;
   logic [15:0] raw;
   logic [4:0] code;
   logic [1:0] oversampling_ratio;
   cfr_seq_mode_t mode;
   logic rd, te_wr, te_in, rr_wr, lc_wr, lc_in;
   logic [2:0] rr_in;
   logic [15:0] live, view;
   logic common_input, summ, vvalid, alert, te, tconv, elkb, ecod, thout, lcur, pora, rdy;
   logic [1:0] eosr;
   logic [2:0] rrange;
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;
   cfr_host_model cfr_host_model_inst (.mclk(mclk), .all_low_kickback(lkb), .status_read(rd),
      .temp_enable_wr(te_wr), .temp_enable_in(te_in), .ref_range_wr(rr_wr), .ref_range_in(rr_in),
      .ref_lowcur_wr(lc_wr), .ref_lowcur_in(lc_in));
   cfr_top cfr_top_inst (.mclk(mclk), .srst(srst), .io_supply_good(io_good),
      .core_supply_good(core_good), .input_clamp_raw(raw), .common_clamp_raw(com_raw),
      .reg_config_mode(cfg_mode), .status_read(rd), .alert_or_threshold_sel(sel),
      .threshold_alert(th_alert), .temp_enable_wr(te_wr), .temp_enable_in(te_in), .seq_mode(mode),
      .seq_last_channel_done(done), .cmd_code_valid(cmd_v), .cmd_channel_code(code),
      .cfg_low_kickback(lkb), .cfg_oversampling_ratio(oversampling_ratio), .cfg_coding(coding),
      .thresh_hit_raw(th_hit), .ref_range_wr(rr_wr), .ref_range_in(rr_in), .ref_lowcur_wr(lc_wr),
      .ref_lowcur_in(lc_in), .input_clamp_active_bit(live), .common_input_clamp_bit(common_input),
      .clamp_summary_flag(summ), .clamp_state_view(view), .clamp_view_valid(vvalid),
      .overvoltage_alert_status_bit(alert), .temp_enable(te), .temp_convert(tconv),
      .eff_low_kickback(elkb), .eff_oversampling_ratio(eosr), .eff_coding(ecod),
      .threshold_alert_out(thout), .ref_range(rrange), .reference_low_current_enable(lcur),
      .por_active(pora), .core_ready(rdy));
   initial begin
      mclk = 1'h0;
      forever #2 mclk = ~mclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checked %0d failed %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 4000) begin
         n_fail++;
         finish_test();
      end
   end
   task automatic wait_ready();
      for (int i = 0; i < 60 && rdy !== 1'h1; i++) @(negedge mclk);
      check({rdy, pora}, 2'h2);
   endtask
   task automatic t_power();
      check(lcur, 1'h1);
      check(pora, 1'h1);
      @(negedge mclk);
      srst = 1'h0;
      io_good = 1'h1;
      repeat (30) @(negedge mclk);
      // Core supply still absent, so no power-on reset may finish
      check(rdy, 1'h0);
      core_good = 1'h1;
      wait_ready();
      check({rrange, lcur, te}, 5'h02);
      $display("power test done");
   endtask
   task automatic t_clamp();
      raw = 16'h0008;
      com_raw = 1'h1;
      repeat (4) @(negedge mclk);
      check(live, 16'h0008);
      check({common_input, summ, alert}, 3'h7);
      cfg_mode = 1'h1;
      repeat (2) @(negedge mclk);
      check({vvalid, view}, 17'h10008);
      cfr_host_model_inst.read_status();
      @(negedge mclk);
      check(summ, 1'h1);
      raw = 16'h0000;
      com_raw = 1'h0;
      repeat (4) @(negedge mclk);
      check({live, common_input, summ, alert}, 19'h00002);
      cfr_host_model_inst.read_status();
      @(negedge mclk);
      check(summ, 1'h0);
      cfg_mode = 1'h0;
      $display("clamp test done");
   endtask
   task automatic t_alert();
      th_alert = 1'h1;
      repeat (3) @(negedge mclk);
      check(alert, 1'h0);
      sel = 1'h1;
      repeat (3) @(negedge mclk);
      check(alert, 1'h1);
      sel = 1'h0;
      th_alert = 1'h0;
      $display("alert test done");
   endtask
   task automatic t_temp_seq();
      cfr_seq_mode_t m [3] = '{CFR_SEQ_STANDARD, CFR_SEQ_ADVANCED, CFR_SEQ_OFF};
      cfr_host_model_inst.write_temp(1'h1);
      lkb = 1'h0;
      oversampling_ratio = 2'h3;
      coding = 1'h1;
      for (int i = 0; i < 3; i++) begin
         mode = m[i];
         done = 1'h1;
         th_hit = 1'h1;
         @(negedge mclk);
         done = 1'h0;
         check(tconv, i < 2);
         check({elkb, eosr, ecod}, i < 2 ? 4'h8 : 4'h7);
         @(negedge mclk);
         check({tconv, thout}, {1'h0, i == 2});
         th_hit = 1'h0;
         repeat (2) @(negedge mclk);
      end
      cfr_host_model_inst.write_temp(1'h0);
      check(te, 1'h0);
      mode = CFR_SEQ_STANDARD;
      done = 1'h1;
      @(negedge mclk);
      done = 1'h0;
      check(tconv, 1'h0);
      mode = CFR_SEQ_OFF;
      $display("sequencer temperature test done");
   endtask
   task automatic t_temp_cmd();
      logic [4:0] c [2] = '{5'h0F, 5'h03};
      mode = CFR_SEQ_COMMAND;
      for (int i = 0; i < 2; i++) begin
         cmd_v = 1'h1;
         code = c[i];
         @(negedge mclk);
         cmd_v = 1'h0;
         code = ~c[i];
         check(tconv, i == 0);
         @(negedge mclk);
      end
      mode = CFR_SEQ_OFF;
      $display("command temperature test done");
   endtask
   task automatic t_ref();
      for (int v = 0; v < 6; v++) begin
         cfr_host_model_inst.write_range(v[2:0]);
         @(negedge mclk);
         check(rrange, v < 5 ? v[2:0] : 3'h4);
      end
      cfr_host_model_inst.write_lowcur(1'h1);
      @(negedge mclk);
      check(lcur, 1'h0);
      lkb = 1'h1;
      cfr_host_model_inst.write_lowcur(1'h1);
      @(negedge mclk);
      check(lcur, 1'h1);
      cfr_host_model_inst.write_lowcur(1'h0);
      lkb = 1'h0;
      core_good = 1'h0;
      repeat (4) @(negedge mclk);
      check(rdy, 1'h0);
      core_good = 1'h1;
      wait_ready();
      check({rrange, lcur}, 4'h1);
      $display("reference test done");
   endtask
   initial begin
      {srst, io_good, core_good, cfg_mode, sel, th_alert, done, cmd_v} = 8'h80;
      {lkb, coding, th_hit, com_raw, raw, code, oversampling_ratio} = 27'h0;
      mode = CFR_SEQ_OFF;
      repeat (10) @(negedge mclk);
      t_power();
      t_clamp();
      t_alert();
      t_temp_seq();
      t_temp_cmd();
      t_ref();
      finish_test();
   end
endmodule
